// *** verilog/ssp_defs.svh ***
// register offsets, field positions and reset values of the serial status block
// assumes byte addressing on a 32-bit classic Wishbone bus, one register per word
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// register byte addresses
`define SSP_ADDR_STATUS   8'h00
`define SSP_ADDR_CONTROL  8'h04
`define SSP_ADDR_MODE     8'h08
`define SSP_ADDR_TXHOLD   8'h0c
`define SSP_ADDR_RXHOLD   8'h10
`define SSP_ADDR_PINCTL   8'h14
`define SSP_ADDR_PINDATA  8'h18

// status bit positions
`define SSP_ST_TX_HOLDING_EMPTY  7
`define SSP_ST_RX_HOLDING_FULL  6
`define SSP_ST_OVERRUN_FLAG  5
`define SSP_ST_FER   4
`define SSP_ST_PER   3
`define SSP_ST_TX_DONE_FLAG  2
`define SSP_ST_MPB   1
`define SSP_ST_TX_MULTIPROC_BIT  0

// control bit positions
`define SSP_CT_TXEN  5
`define SSP_CT_RXEN  4
`define SSP_CT_CLOCK_SOURCE_EXTERNAL_SEL  1
`define SSP_CT_CLOCK_OUTPUT_EN  0

// mode bit positions
`define SSP_MD_CLKSYNC  7
`define SSP_MD_PAREN    5
`define SSP_MD_ODD      4
`define SSP_MD_STOP2    3
`define SSP_MD_MP       2

// pin control and pin data fields
`define SSP_PC_CLKMD_HI  3
`define SSP_PC_CLKMD_LO  2
`define SSP_PC_TXMD_HI   1
`define SSP_PC_TXMD_LO   0
`define SSP_PD_CLKDT     1
`define SSP_PD_TXDT      0

// reset values
`define SSP_STATUS_RESET   8'h84
`define SSP_CONTROL_RESET  8'h00
`define SSP_MODE_RESET     8'h00
`define SSP_HOLD_RESET     8'h00
`define SSP_PINCTL_RESET   16'h0000
`define SSP_PINDATA_RESET  2'h0

`endif

// *** verilog/ssp_pkg.sv ***
// types shared by the serial status block
// assumes ssp_defs.svh supplies the numeric constants
package ssp_pkg;
   typedef logic [7:0] ssp_addr_t;
   typedef logic [7:0] ssp_byte_t;
   // pin port mode field codes
   typedef enum logic [1:0] {
      SSP_PM_OFF   = 2'b00,
      SSP_PM_DRIVE = 2'b01,
      SSP_PM_READ  = 2'b10,
      SSP_PM_RSVD  = 2'b11
   } ssp_pmode_e;
endpackage

// *** verilog/ssp_serial_status.sv ***
// serial unit status flags, clock pin selection and pin port control
// assumes shift engines on clk give one-cycle event pulses and a received character
//
// Behaviour
// - internal clock output drives pin at bit rate
// - writes never set flags; clear needs prior read (a holding register write or read clears without one)
// - status is 8 bits, initialises to 84
// - transmit-end and received mp bit read-only
// - transmit-empty set and clear conditions
// - receive-full set and clear conditions
// - errors or receive disable keep holding data
// - overrun keeps old data, drops new character
// - errors halt receive, also transmit when clocked
// - framing error from first stop bit only
// - framing or parity error loads data, no full
// - parity error when ones count mismatches setting
// - receive disable keeps the error flags
// - transmit-end set on empty last bit
// - capture received mp bit, hold on disable
// - append mp transfer bit only async mp
// - clock pin port mode off, drive, read
// - transmit pin port drive for break
// - receive enable makes tx data read pin
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_serial_status (
   // clock, reset and standby
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               standby,
   // wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire ssp_pkg::ssp_addr_t wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   // shift engine side
   input  wire logic               bitRateClk,
   input  wire logic               txLoadEvt,
   input  wire logic               txLastBitEvt,
   input  wire logic               rxDoneEvt,
   input  wire ssp_pkg::ssp_byte_t rxChar,
   input  wire logic               rxParityBit,
   input  wire logic               rxStopBit,
   input  wire logic               rxMpBit,
   output ssp_pkg::ssp_byte_t      txHoldData,
   output logic                    txHoldEmpty,
   output logic                    txMpBit,
   output logic                    txEnOut,
   output logic                    rxEnOut,
   output ssp_pkg::ssp_byte_t      modeOut,
   output logic                    rxHalt,
   output logic                    txHalt,
   output logic                    extClkEdge,
   // pins
   input  wire logic               sckPinIn,
   input  wire logic               rxPinIn,
   output logic                    sckPinOut,
   output logic                    sckPinOe,
   output logic                    txPinOut,
   output logic                    txPinOe
);
   import ssp_pkg::*;

   // state
   logic        ack_ff;
   logic [31:0] rdData_ff;
   logic        tx_holding_empty_ff, rx_holding_full_ff, overrun_flag_ff, fer_ff, per_ff, tx_done_flag_ff, mpb_ff, tx_multiproc_bit_ff;
   logic [4:0]  arm_ff;
   ssp_byte_t   ctl_ff, mode_ff, txHold_ff, rxHold_ff;
   logic [15:0] pinCtl_ff;
   logic [1:0]  pinData_ff;
   logic        sckMeta_ff, sckSync_ff, sckPrev_ff, rxMeta_ff, rxSync_ff;
   logic        sckOut_ff, sckOe_ff, txOut_ff, txOe_ff, extEdge_ff, rxHalt_ff, txHalt_ff;

   // a flag may be cleared by a status write only when armed and written 0
   function automatic logic swClear(input logic wr, input logic armed, input logic wbit);
      swClear = wr & armed & ~wbit;
   endfunction

   // bus decode
   wire        acc       = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire        wr        = acc & wb_we_i;
   wire        rd        = acc & ~wb_we_i;
   wire        hitStat   = (wb_adr_i == `SSP_ADDR_STATUS);
   wire        hitCtl    = (wb_adr_i == `SSP_ADDR_CONTROL);
   wire        hitMode   = (wb_adr_i == `SSP_ADDR_MODE);
   wire        hitTx     = (wb_adr_i == `SSP_ADDR_TXHOLD);
   wire        hitRx     = (wb_adr_i == `SSP_ADDR_RXHOLD);
   wire        hitPc     = (wb_adr_i == `SSP_ADDR_PINCTL);
   wire        hitPd     = (wb_adr_i == `SSP_ADDR_PINDATA);
   wire        wrLo      = wr & wb_sel_i[0];
   wire        statWr    = wrLo & hitStat;
   wire        statRd    = rd & hitStat;
   wire        txHoldWr  = wrLo & hitTx;
   wire        rxHoldRd  = rd & hitRx;
   wire [7:0]  wd        = wb_dat_i[7:0];

   // decoded settings
   wire        init      = standby;
   wire        txEn      = ctl_ff[`SSP_CT_TXEN];
   wire        rxEn      = ctl_ff[`SSP_CT_RXEN];
   wire        clock_source_external_sel      = ctl_ff[`SSP_CT_CLOCK_SOURCE_EXTERNAL_SEL];
   wire        clock_output_en      = ctl_ff[`SSP_CT_CLOCK_OUTPUT_EN];
   wire        clocked   = mode_ff[`SSP_MD_CLKSYNC];
   wire        mpMode    = mode_ff[`SSP_MD_MP] & ~clocked;
   wire        parOn     = mode_ff[`SSP_MD_PAREN] & ~mpMode & ~clocked;
   wire        oddPar    = mode_ff[`SSP_MD_ODD];
   ssp_pmode_e pmClk, pmTx;
   assign pmClk = ssp_pmode_e'(pinCtl_ff[`SSP_PC_CLKMD_HI:`SSP_PC_CLKMD_LO]);
   assign pmTx  = ssp_pmode_e'(pinCtl_ff[`SSP_PC_TXMD_HI:`SSP_PC_TXMD_LO]);
   wire [7:0]  statusVal = {tx_holding_empty_ff, rx_holding_full_ff, overrun_flag_ff, fer_ff, per_ff,
                            tx_done_flag_ff, mpb_ff, tx_multiproc_bit_ff};

   // receive event evaluation
   // errors halt receive
   wire        errAny    = overrun_flag_ff | fer_ff | per_ff;
   wire        rxTake    = rxDoneEvt & rxEn & ~errAny;
   wire        frErr     = ~clocked & ~rxStopBit;
   wire        parErr    = parOn & ((^{rxChar, rxParityBit}) != oddPar);
   wire        overrun   = rxTake & rx_holding_full_ff;
   wire        loadRx    = rxTake & ~rx_holding_full_ff;
   wire        rdrfSet   = loadRx & ~frErr & ~parErr;

   // flag clear terms
   // armed status-write clear, or holding register write or read
   wire        txClr     = swClear(statWr, arm_ff[4], wd[`SSP_ST_TX_HOLDING_EMPTY]) | txHoldWr;
   wire        rdrfClr   = swClear(statWr, arm_ff[3], wd[`SSP_ST_RX_HOLDING_FULL]) | rxHoldRd;
   wire        orerClr   = swClear(statWr, arm_ff[2], wd[`SSP_ST_OVERRUN_FLAG]);
   wire        ferClr    = swClear(statWr, arm_ff[1], wd[`SSP_ST_FER]);
   wire        perClr    = swClear(statWr, arm_ff[0], wd[`SSP_ST_PER]);

   // next flag values, set wins over clear
   // transmit-empty flag
   wire nxt_tx_holding_empty = init | ~txEn | txLoadEvt | (tx_holding_empty_ff & ~txClr);
   wire nxt_tx_done_flag = init | ~txEn | (txLastBitEvt & tx_holding_empty_ff) | (tx_done_flag_ff & ~txClr);
   wire nxt_rx_holding_full = ~init & (rdrfSet | (rx_holding_full_ff & ~rdrfClr));
   wire nxt_overrun_flag = ~init & (overrun | (overrun_flag_ff & ~orerClr));
   wire nxt_fer  = ~init & ((loadRx & frErr) | (fer_ff & ~ferClr));
   wire nxt_per  = ~init & ((loadRx & parErr) | (per_ff & ~perClr));
   wire nxt_mpb  = ~init & ((rxTake & mpMode) ? rxMpBit : mpb_ff);
   wire nxt_tx_multiproc_bit = ~init & (statWr ? wd[`SSP_ST_TX_MULTIPROC_BIT] : tx_multiproc_bit_ff);
   // writes never set flags, read arms
   wire [4:0] nxt_arm = statRd ? statusVal[7:3] : (arm_ff & statusVal[7:3]);

   // holding and control registers
   // receive holding data only changes on load, transmit holding data on a bus write
   wire [7:0]  nxt_rxHold  = loadRx ? rxChar : rxHold_ff;
   wire [7:0]  nxt_txHold  = txHoldWr ? wd : txHold_ff;
   wire [7:0]  nxt_ctl     = init ? `SSP_CONTROL_RESET : ((wrLo & hitCtl) ? wd : ctl_ff);
   wire [7:0]  nxt_mode    = init ? `SSP_MODE_RESET : ((wrLo & hitMode) ? wd : mode_ff);
   wire [15:0] nxt_pinCtl  = {(wr & wb_sel_i[1] & hitPc) ? wb_dat_i[15:8] : pinCtl_ff[15:8],
                              (wrLo & hitPc) ? wd : pinCtl_ff[7:0]};
   wire [1:0]  nxt_pinData = (wrLo & hitPd) ? wd[1:0] : pinData_ff;

   // pin data readback
   // receive pin on tx data
   wire        pdTxRd   = rxEn ? rxSync_ff : pinData_ff[`SSP_PD_TXDT];
   wire        pdClkRd  = (pmClk == SSP_PM_READ) ? sckSync_ff : pinData_ff[`SSP_PD_CLKDT];

   // read data select, unmapped reads as zero
   wire [31:0] nxt_rdData = hitStat ? {24'h0, statusVal} :
                            hitCtl  ? {24'h0, ctl_ff} :
                            hitMode ? {24'h0, mode_ff} :
                            hitTx   ? {24'h0, txHold_ff} :
                            hitRx   ? {24'h0, rxHold_ff} :
                            hitPc   ? {16'h0, pinCtl_ff} :
                            hitPd   ? {30'h0, pdClkRd, pdTxRd} : 32'h0;

   // clock pin drive
   // port drive of clock pin
   wire pmClkDrive  = (pmClk == SSP_PM_DRIVE);
   // internal clock output at bit rate
   wire intClkOut   = ~clock_source_external_sel & (clock_output_en | clocked);
   wire nxt_sckOe   = pmClkDrive | intClkOut;
   wire nxt_sckOut  = pmClkDrive ? pinData_ff[`SSP_PD_CLKDT] : bitRateClk;
   // external clock edges counted by engines
   wire nxt_extEdge = clock_source_external_sel & sckSync_ff & ~sckPrev_ff;
   wire nxt_txOe    = (pmTx == SSP_PM_DRIVE);

   // bus handshake, one wait cycle, then one answer cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff    <= 1'b0;
         rdData_ff <= 32'h0;
      end else begin
         ack_ff    <= acc;
         rdData_ff <= rd ? nxt_rdData : 32'h0;
      end
   end

   // status flags and read latches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {tx_holding_empty_ff, rx_holding_full_ff, overrun_flag_ff, fer_ff, per_ff, tx_done_flag_ff, mpb_ff, tx_multiproc_bit_ff}
            <= `SSP_STATUS_RESET;
         arm_ff <= 5'h0;
      end else begin
         {tx_holding_empty_ff, rx_holding_full_ff, overrun_flag_ff, fer_ff, per_ff, tx_done_flag_ff, mpb_ff, tx_multiproc_bit_ff}
            <= {nxt_tx_holding_empty, nxt_rx_holding_full, nxt_overrun_flag, nxt_fer, nxt_per, nxt_tx_done_flag, nxt_mpb, nxt_tx_multiproc_bit};
         arm_ff <= nxt_arm;
      end
   end

   // data, control and pin port registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_ff     <= `SSP_CONTROL_RESET;
         mode_ff    <= `SSP_MODE_RESET;
         txHold_ff  <= `SSP_HOLD_RESET;
         rxHold_ff  <= `SSP_HOLD_RESET;
         pinCtl_ff  <= `SSP_PINCTL_RESET;
         pinData_ff <= `SSP_PINDATA_RESET;
      end else begin
         ctl_ff     <= nxt_ctl;
         mode_ff    <= nxt_mode;
         txHold_ff  <= nxt_txHold;
         rxHold_ff  <= nxt_rxHold;
         pinCtl_ff  <= nxt_pinCtl;
         pinData_ff <= nxt_pinData;
      end
   end

   // pin synchronisers, edge finder and registered pin drives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sckMeta_ff, sckSync_ff, sckPrev_ff, rxMeta_ff, rxSync_ff} <= 5'h0;
         {sckOut_ff, sckOe_ff, txOut_ff, txOe_ff, extEdge_ff}       <= 5'h0;
         {rxHalt_ff, txHalt_ff}                                     <= 2'h0;
         txMpBit <= 1'b0;
      end else begin
         {sckMeta_ff, sckSync_ff, sckPrev_ff} <= {sckPinIn, sckMeta_ff, sckSync_ff};
         {rxMeta_ff, rxSync_ff}               <= {rxPinIn, rxMeta_ff};
         {sckOut_ff, sckOe_ff, extEdge_ff}    <= {nxt_sckOut, nxt_sckOe, nxt_extEdge};
         {txOut_ff, txOe_ff}                  <= {pinData_ff[`SSP_PD_TXDT], nxt_txOe};
         {rxHalt_ff, txHalt_ff}               <= {errAny, errAny & clocked};
         txMpBit                              <= mpMode & tx_multiproc_bit_ff;
      end
   end

   // outputs straight from flops
   assign wb_ack_o    = ack_ff;
   assign wb_dat_o    = rdData_ff;
   assign txHoldData  = txHold_ff;
   assign txHoldEmpty = tx_holding_empty_ff;
   assign txEnOut     = txEn;
   assign rxEnOut     = rxEn;
   assign modeOut     = mode_ff;
   assign rxHalt      = rxHalt_ff;
   assign txHalt      = txHalt_ff;
   assign extClkEdge  = extEdge_ff;
   assign sckPinOut   = sckOut_ff;
   assign sckPinOe    = sckOe_ff;
   assign txPinOut    = txOut_ff;
   assign txPinOe     = txOe_ff;

   // checks on the flag and clock pin behaviour
   property p_noWriteSet;
      @(posedge clk) disable iff (!rst_n)
      statWr && !rx_holding_full_ff && !rdrfSet |=> !rx_holding_full_ff;
   endproperty
   a_noWriteSet: assert property (p_noWriteSet) else $error("write set receive-full");

   property p_initValue;
      @(posedge clk) disable iff (!rst_n)
      standby |=> (statusVal == `SSP_STATUS_RESET) && (ctl_ff == `SSP_CONTROL_RESET);
   endproperty
   a_initValue: assert property (p_initValue) else $error("status not initialised");

   property p_tendReadOnly;
      @(posedge clk) disable iff (!rst_n)
      statWr && txEn && !txLastBitEvt && !standby && !txClr && !rxTake
         |=> $stable(tx_done_flag_ff) && $stable(mpb_ff);
   endproperty
   a_tendReadOnly: assert property (p_tendReadOnly) else $error("read-only bit written");

   property p_txEmptyOnDisable;
      @(posedge clk) disable iff (!rst_n)
      !txEn |=> tx_holding_empty_ff && tx_done_flag_ff;
   endproperty
   a_txEmptyOnDisable: assert property (p_txEmptyOnDisable) else $error("tx flags not set");

   property p_rdrfReadClear;
      @(posedge clk) disable iff (!rst_n)
      rxHoldRd && !rdrfSet ##1 wb_ack_o |-> !rx_holding_full_ff && wb_dat_o[7:0] == $past(rxHold_ff);
   endproperty
   a_rdrfReadClear: assert property (p_rdrfReadClear) else $error("read did not clear full");

   property p_overrunKeeps;
      @(posedge clk) disable iff (!rst_n)
      overrun && !standby && !rdrfClr
         |=> overrun_flag_ff && rx_holding_full_ff && (rxHold_ff == $past(rxHold_ff)) ##1 rxHalt;
   endproperty
   a_overrunKeeps: assert property (p_overrunKeeps) else $error("overrun lost old data");

   property p_frameLoad;
      @(posedge clk) disable iff (!rst_n)
      loadRx && frErr && !standby |=> fer_ff && !rx_holding_full_ff && rxHold_ff == $past(rxChar);
   endproperty
   a_frameLoad: assert property (p_frameLoad) else $error("framing error handling wrong");

   property p_unarmedKeep;
      @(posedge clk) disable iff (!rst_n)
      statWr && !arm_ff[2] && !standby |=> overrun_flag_ff == $past(overrun_flag_ff) || overrun_flag_ff;
   endproperty
   a_unarmedKeep: assert property (p_unarmedKeep) else $error("unarmed clear of overrun");

   property p_clkPortDrive;
      @(posedge clk) disable iff (!rst_n)
      pmClkDrive |=> sckPinOe && sckPinOut == $past(pinData_ff[`SSP_PD_CLKDT]);
   endproperty
   a_clkPortDrive: assert property (p_clkPortDrive) else $error("clock pin port drive wrong");

   property p_errHold;
      @(posedge clk) disable iff (!rst_n)
      fer_ff && !standby && !ferClr |=> fer_ff;
   endproperty
   a_errHold: assert property (p_errHold) else $error("framing flag lost");
endmodule

// *** tb/ssp_serial_peer.sv ***
// far-side serial partner: hands finished characters to the block and makes the link clock
// assumes calls start just after a rising clk edge; the link clock ignores clk
`timescale 1ns/1ps
module ssp_serial_peer (
   // host clock
   input  wire logic          clk,
   // received character side
   output logic               rxDoneEvt,
   output ssp_pkg::ssp_byte_t rxChar,
   output logic               rxParityBit,
   output logic               rxStopBit,
   output logic               rxMpBit,
   // pins
   output logic               sckPinIn,
   output logic               rxPinIn
);
   import ssp_pkg::*;
   // idle line at mark level, link clock parked low
   initial begin
      rxDoneEvt = 1'b0;
      rxChar = 8'h00;
      rxParityBit = 1'b0;
      rxStopBit = 1'b1;
      rxMpBit = 1'b0;
      sckPinIn = 1'b0;
      rxPinIn = 1'b1;
   end
   // one character for a single cycle, then the fields turn stale
   task automatic send(input ssp_byte_t c, input logic p, input logic s, input logic m);
      rxDoneEvt <= 1'b1;
      rxChar <= c;
      rxParityBit <= p;
      rxStopBit <= s;
      rxMpBit <= m;
      @(posedge clk);
      rxDoneEvt <= 1'b0;
      rxChar <= ~c;
      rxParityBit <= ~p;
      rxStopBit <= ~s;
      rxMpBit <= ~m;
      // one quiet cycle so back-to-back calls never drive the strobe twice at one edge
      @(posedge clk);
   endtask
   task automatic burst(input int n);
      #7;
      repeat (n) begin
         #100 sckPinIn = 1'b1;
         #100 sckPinIn = 1'b0;
      end
   endtask
endmodule

// *** tb/tb_ssp_serial_status.sv ***
// self-checking bench for the serial status block: register rows, then hand cases
// assumes the peer model drives the receive side and the link clock pin
`timescale 1ns/1ps
`include "ssp_defs.svh"
module tb_ssp_serial_status;
   import ssp_pkg::*;
   typedef struct {ssp_addr_t a; logic [31:0] w; logic [31:0] e;} ssp_row_s;
   logic        clk, rst_n, standby, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   ssp_addr_t   wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic        bitRateClk, txLoadEvt, txLastBitEvt, rxDoneEvt, rxParityBit, rxStopBit;
   logic        rxMpBit, sckPinIn, rxPinIn, txHoldEmpty, txMpBit, txEnOut, rxEnOut;
   logic        rxHalt, txHalt, extClkEdge, sckPinOut, sckPinOe, txPinOut, txPinOe;
   ssp_byte_t   rxChar, txHoldData, modeOut;
   int          n_mismatch, n_compared, nEdge;
   ssp_row_s    rows[10];

   ssp_serial_status dut_u (.clk(clk), .rst_n(rst_n), .standby(standby),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .bitRateClk(bitRateClk), .txLoadEvt(txLoadEvt), .txLastBitEvt(txLastBitEvt),
      .rxDoneEvt(rxDoneEvt), .rxChar(rxChar), .rxParityBit(rxParityBit),
      .rxStopBit(rxStopBit), .rxMpBit(rxMpBit), .txHoldData(txHoldData),
      .txHoldEmpty(txHoldEmpty), .txMpBit(txMpBit), .txEnOut(txEnOut), .rxEnOut(rxEnOut),
      .modeOut(modeOut), .rxHalt(rxHalt), .txHalt(txHalt), .extClkEdge(extClkEdge),
      .sckPinIn(sckPinIn), .rxPinIn(rxPinIn), .sckPinOut(sckPinOut), .sckPinOe(sckPinOe),
      .txPinOut(txPinOut), .txPinOe(txPinOe));
   ssp_serial_peer peer_u (.clk(clk), .rxDoneEvt(rxDoneEvt), .rxChar(rxChar),
      .rxParityBit(rxParityBit), .rxStopBit(rxStopBit), .rxMpBit(rxMpBit),
      .sckPinIn(sckPinIn), .rxPinIn(rxPinIn));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // counts detected link clock edges
   always @(posedge clk) begin
      if (rst_n !== 1'b1) nEdge <= 0;
      else if (extClkEdge === 1'b1) nEdge <= nEdge + 1;
   end
   // closing report and verdict
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // compares one value
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one classic cycle; waits for ack, then one idle cycle
   task automatic bus(input ssp_addr_t a, input logic we, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk);
   endtask
   // read and compare
   task automatic rc(input ssp_addr_t a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(q, e);
   endtask
   // hang guard
   initial begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      standby = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h3;
      wb_dat_i = 32'h0;
      bitRateClk = 1'b0;
      txLoadEvt = 1'b0;
      txLastBitEvt = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      rows[0] = '{`SSP_ADDR_STATUS, 32'h00, 32'h84};
      rows[1] = '{`SSP_ADDR_CONTROL, 32'h30, 32'h30};
      rows[2] = '{`SSP_ADDR_STATUS, 32'hff, 32'h85};
      rows[3] = '{`SSP_ADDR_STATUS, 32'h00, 32'h00};
      rows[4] = '{`SSP_ADDR_CONTROL, 32'h10, 32'h10};
      rows[5] = '{`SSP_ADDR_STATUS, 32'h7a, 32'h84};
      rows[6] = '{`SSP_ADDR_MODE, 32'h38, 32'h38};
      rows[7] = '{`SSP_ADDR_PINCTL, 32'h05, 32'h05};
      rows[8] = '{`SSP_ADDR_PINDATA, 32'h02, 32'h03};
      rows[9] = '{8'h1c, 32'hff, 32'h00};
      repeat (6) @(posedge clk);
      chk(32'(txHoldEmpty), 32'h1);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(rows[i].a, 1'b1, rows[i].w);
         rc(rows[i].a, rows[i].e);
      end
      chk(32'({sckPinOe, sckPinOut, txPinOe, txPinOut}), 32'he);
      bus(`SSP_ADDR_PINCTL, 1'b1, 32'h08);
      rc(`SSP_ADDR_PINDATA, 32'h01);
      chk(32'(sckPinOe), 32'h0);
      bus(`SSP_ADDR_PINCTL, 1'b1, 32'h0);
      bus(`SSP_ADDR_MODE, 1'b1, 32'h0);
      // receive: full, overrun, framing, parity
      peer_u.send(8'h5a, 1'b0, 1'b1, 1'b0);
      rc(`SSP_ADDR_STATUS, 32'hc4);
      rc(`SSP_ADDR_RXHOLD, 32'h5a);
      rc(`SSP_ADDR_STATUS, 32'h84);
      peer_u.send(8'h11, 1'b0, 1'b1, 1'b0);
      peer_u.send(8'h22, 1'b0, 1'b1, 1'b0);
      rc(`SSP_ADDR_STATUS, 32'he4);
      chk(32'(rxHalt), 32'h1);
      peer_u.send(8'h44, 1'b0, 1'b1, 1'b0);
      rc(`SSP_ADDR_RXHOLD, 32'h11);
      bus(`SSP_ADDR_STATUS, 1'b1, 32'h80);
      rc(`SSP_ADDR_STATUS, 32'h84);
      peer_u.send(8'h33, 1'b0, 1'b0, 1'b0);
      rc(`SSP_ADDR_STATUS, 32'h94);
      rc(`SSP_ADDR_RXHOLD, 32'h33);
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h0);
      rc(`SSP_ADDR_STATUS, 32'h94);
      bus(`SSP_ADDR_STATUS, 1'b1, 32'h80);
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h10);
      bus(`SSP_ADDR_MODE, 1'b1, 32'h20);
      peer_u.send(8'h01, 1'b0, 1'b1, 1'b0);
      rc(`SSP_ADDR_STATUS, 32'h8c);
      // multiprocessor bits
      bus(`SSP_ADDR_MODE, 1'b1, 32'h04);
      bus(`SSP_ADDR_STATUS, 1'b1, 32'h81);
      chk(32'(txMpBit), 32'h1);
      peer_u.send(8'h7e, 1'b0, 1'b1, 1'b1);
      rc(`SSP_ADDR_STATUS, 32'hc7);
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h0);
      rc(`SSP_ADDR_STATUS, 32'hc7);
      bus(`SSP_ADDR_MODE, 1'b1, 32'h84);
      chk(32'(txMpBit), 32'h0);
      bus(`SSP_ADDR_MODE, 1'b1, 32'h0);
      rc(`SSP_ADDR_RXHOLD, 32'h7e);
      // transmit: empty and done
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h20);
      bus(`SSP_ADDR_TXHOLD, 1'b1, 32'ha5);
      rc(`SSP_ADDR_STATUS, 32'h03);
      chk(32'(txHoldData), 32'ha5);
      txLoadEvt <= 1'b1;
      @(posedge clk);
      txLoadEvt <= 1'b0;
      rc(`SSP_ADDR_STATUS, 32'h83);
      txLastBitEvt <= 1'b1;
      @(posedge clk);
      txLastBitEvt <= 1'b0;
      rc(`SSP_ADDR_STATUS, 32'h87);
      bus(`SSP_ADDR_TXHOLD, 1'b1, 32'h5a);
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h0);
      rc(`SSP_ADDR_STATUS, 32'h87);
      // clock pin: internal output, then external input
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h01);
      bitRateClk <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'({sckPinOe, sckPinOut}), 32'h3);
      bitRateClk <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'({sckPinOe, sckPinOut}), 32'h2);
      bus(`SSP_ADDR_CONTROL, 1'b1, 32'h02);
      peer_u.burst(8);
      repeat (4) @(posedge clk);
      chk(32'({sckPinOe, nEdge[7:0]}), 32'h8);
      // standby and a second reset
      standby <= 1'b1;
      @(posedge clk);
      standby <= 1'b0;
      rc(`SSP_ADDR_STATUS, 32'h84);
      rc(`SSP_ADDR_CONTROL, 32'h0);
      rst_n <= 1'b0;
      @(posedge clk);
      chk(32'(txHoldEmpty), 32'h1);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(`SSP_ADDR_STATUS, 32'h84);
      give_verdict();
   end
endmodule
